// file: rtl/tone_and_am_avoid_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "tone_regs_consts.vh"

module tone_and_am_avoid_regs #(
  parameter [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
  input  wire        CLK,
  input  wire        RSTN,
  input  wire        CE,
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  input  wire [3:0]  TONE_INLINE,
  output wire [31:0] BASS_GAIN_INDEX,
  output wire [31:0] TREBLE_GAIN_INDEX,
  output wire [23:0] BASS_GAIN_DB,
  output wire [23:0] TREBLE_GAIN_DB,
  output wire [11:0] TREBLE_SET,
  output wire        AM_ENABLE,
  output wire [1:0]  AM_SEQUENCE,
  output wire        AM_METHOD,
  output wire        AM_IF_SEL,
  output wire        AM_BINARY,
  output wire [15:0] AM_TUNED_FREQ
);

  // one-hot serial port states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_SUB  = 9'h008;
  localparam [8:0] ST_SACK = 9'h010;
  localparam [8:0] ST_WDAT = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RDAT = 9'h080;
  localparam [8:0] ST_MACK = 9'h100;

  reg  [2:0]  scl_sync_reg;
  reg  [2:0]  sda_sync_reg;
  reg  [8:0]  state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  sub_reg;
  reg  [1:0]  byte_idx_reg;
  reg  [23:0] wbuf_reg;
  reg  [31:0] rword_reg;
  reg         rw_reg;
  reg         nack_reg;
  reg         sda_oe_reg;
  reg         sda_out_reg;
  reg  [31:0] bass_reg;
  reg  [31:0] treble_reg;
  reg  [31:0] tsel_reg;
  reg  [31:0] am_reg;
  reg         am_en_reg;
  reg  [1:0]  am_seq_reg;
  reg         am_meth_reg;
  reg         am_if_reg;
  reg         am_bin_reg;
  reg  [15:0] am_freq_reg;

  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        byte_full;
  wire        wr_commit;
  wire [31:0] wr_data;
  reg  [31:0] rd_word;
  reg  [31:0] am_next;

  // second stage and its delayed copy feed the edge logic; first stage only feeds the second
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_s & scl_sync_reg[2];
  assign start_det = scl_s & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_s;
  assign stop_det  = scl_s & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_s;
  assign byte_full = (bit_cnt_reg == `BIT_COUNT_BYTE);
  // a word lands only when its fourth byte is complete
  assign wr_commit = CE & (state_reg == ST_WDAT) & scl_fall & byte_full &
                     (byte_idx_reg == `BYTES_PER_WORD_M1);
  assign wr_data   = {wbuf_reg, shift_reg};

  // pin synchronisers
  always @(posedge CLK) begin
    if (!RSTN) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else if (CE) begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
    end
  end

  // read mux; unmapped subaddresses read zero
  always @* begin
    case (sub_reg)
      `SUB_BASS_GAIN_INDEX:      rd_word = bass_reg;
      `SUB_TREBLE_CORNER_SELECT: rd_word = tsel_reg;
      `SUB_TREBLE_GAIN_INDEX:    rd_word = treble_reg;
      `SUB_AM_AVOIDANCE_MODE:    rd_word = am_reg;
      default:                   rd_word = 32'h00000000;
    endcase
  end

  // serial port: sample on scl rise, change sda on scl fall
  always @(posedge CLK) begin
    if (!RSTN) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      sub_reg      <= 8'h00;
      byte_idx_reg <= 2'h0;
      wbuf_reg     <= 24'h000000;
      rword_reg    <= 32'h00000000;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      sda_oe_reg   <= 1'b0;
      sda_out_reg  <= 1'b0;
    end else if (CE) begin
      if (start_det) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg  <= 1'b0;
      end else if (stop_det) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          ST_ADDR, ST_SUB, ST_WDAT: begin
            if (scl_rise && !byte_full) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && byte_full) begin
              bit_cnt_reg <= 4'h0;
              sda_oe_reg  <= 1'b1;  // acknowledge low
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  rw_reg       <= shift_reg[0];
                  byte_idx_reg <= 2'h0;
                  rword_reg    <= rd_word;
                  state_reg    <= ST_AACK;
                end else begin
                  // another device is addressed; stay quiet until the next start
                  sda_oe_reg <= 1'b0;
                  state_reg  <= ST_IDLE;
                end
              end else if (state_reg == ST_SUB) begin
                sub_reg      <= shift_reg;
                byte_idx_reg <= 2'h0;
                state_reg    <= ST_SACK;
              end else begin
                wbuf_reg     <= {wbuf_reg[15:0], shift_reg};
                byte_idx_reg <= byte_idx_reg + 2'h1;
                state_reg    <= ST_WACK;
              end
            end
          end
          ST_AACK, ST_SACK, ST_WACK: begin
            if (scl_fall) begin
              if (state_reg == ST_AACK && rw_reg) begin
                sda_oe_reg <= ~rword_reg[31];
                state_reg  <= ST_RDAT;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg  <= (state_reg == ST_AACK) ? ST_SUB : ST_WDAT;
              end
            end
          end
          ST_RDAT: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == `BIT_COUNT_BYTE) begin
                bit_cnt_reg <= 4'h0;
                sda_oe_reg  <= 1'b0;  // release for the master's answer
                rword_reg   <= {rword_reg[23:0], 8'h00};
                state_reg   <= ST_MACK;
              end else begin
                sda_oe_reg <= ~rword_reg[4'h7 - bit_cnt_reg[2:0] + 5'h18];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s;
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                // words longer than four bytes read zero past the end
                sda_oe_reg <= ~rword_reg[31];
                state_reg  <= ST_RDAT;
              end
            end
          end
          default: begin
            state_reg  <= ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // am word with reserved bits cleared, binary mode high bits forced low
  always @* begin
    am_next = wr_data & `MASK_AM_AVOIDANCE_MODE;
    if (am_next[`AM_BINARY_BIT]) begin
      am_next[15:11] = 5'h00;
    end else begin
      am_next[15:13] = 3'h0;
      am_next[3:0]   = 4'h0;
    end
  end

  // register bank writes; an out of range index is kept as written
  always @(posedge CLK) begin
    if (!RSTN) begin
      bass_reg   <= `RST_BASS_GAIN_INDEX;
      treble_reg <= `RST_TREBLE_GAIN_INDEX;
      tsel_reg   <= `RST_TREBLE_CORNER_SELECT;
      am_reg     <= `RST_AM_AVOIDANCE_MODE;
    end else if (wr_commit) begin
      case (sub_reg)
        `SUB_BASS_GAIN_INDEX:      bass_reg   <= wr_data;
        `SUB_TREBLE_GAIN_INDEX:    treble_reg <= wr_data;
        `SUB_TREBLE_CORNER_SELECT: tsel_reg   <= wr_data & `MASK_TREBLE_CORNER_SELECT;
        `SUB_AM_AVOIDANCE_MODE:    am_reg     <= am_next;
        default: begin
        end
      endcase
    end
  end

  // decoded am controls, registered for clean outputs
  always @(posedge CLK) begin
    if (!RSTN) begin
      am_en_reg   <= 1'b0;
      am_seq_reg  <= 2'h0;
      am_meth_reg <= 1'b0;
      am_if_reg   <= 1'b0;
      am_bin_reg  <= 1'b0;
      am_freq_reg <= 16'h0000;
    end else if (CE) begin
      am_en_reg   <= am_reg[`AM_ENABLE_BIT];
      am_seq_reg  <= am_reg[`AM_SEQ_HI:`AM_SEQ_LO];
      am_meth_reg <= am_reg[`AM_METHOD_BIT];
      am_if_reg   <= am_reg[`AM_IF_BIT];
      am_bin_reg  <= am_reg[`AM_BINARY_BIT];
      am_freq_reg <= am_reg[15:0];
    end
  end

  // per channel group: gain in signed dB and the live treble corner set
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      reg  [5:0] bass_db_reg;
      reg  [5:0] treble_db_reg;
      reg  [2:0] tset_reg;
      wire [7:0] bass_idx   = bass_reg[8*g+7:8*g];
      wire [7:0] treble_idx = treble_reg[8*g+7:8*g];
      wire [2:0] tcode      = wr_data[8*g+2:8*g];

      // 18 minus index; invalid indexes saturate at the bottom rather than wrap
      always @(posedge CLK) begin
        if (!RSTN) begin
          bass_db_reg   <= `GAIN_DB_ZERO;
          treble_db_reg <= `GAIN_DB_ZERO;
        end else if (CE) begin
          if (!TONE_INLINE[g]) begin
            bass_db_reg   <= `GAIN_DB_ZERO;
            treble_db_reg <= `GAIN_DB_ZERO;
          end else begin
            bass_db_reg   <= (bass_idx > `GAIN_INDEX_MAX) ? `GAIN_DB_BOTTOM :
                             (`GAIN_DB_TOP - bass_idx[5:0]);
            treble_db_reg <= (treble_idx > `GAIN_INDEX_MAX) ? `GAIN_DB_BOTTOM :
                             (`GAIN_DB_TOP - treble_idx[5:0]);
          end
        end
      end

      // zero and illegal codes leave the active set alone
      always @(posedge CLK) begin
        if (!RSTN) begin
          tset_reg <= `RST_TREBLE_ACTIVE_SET;
        end else if (wr_commit && sub_reg == `SUB_TREBLE_CORNER_SELECT &&
                     tcode >= `TREBLE_CODE_FIRST && tcode <= `TREBLE_CODE_LAST) begin
          tset_reg <= tcode;
        end
      end

      assign BASS_GAIN_DB[6*g+5:6*g]   = bass_db_reg;
      assign TREBLE_GAIN_DB[6*g+5:6*g] = treble_db_reg;
      assign TREBLE_SET[3*g+2:3*g]     = tset_reg;
    end
  endgenerate

  assign SDA_OUT           = sda_out_reg;
  assign SDA_OE            = sda_oe_reg;
  assign BASS_GAIN_INDEX   = bass_reg;
  assign TREBLE_GAIN_INDEX = treble_reg;
  assign AM_ENABLE         = am_en_reg;
  assign AM_SEQUENCE       = am_seq_reg;
  assign AM_METHOD         = am_meth_reg;
  assign AM_IF_SEL         = am_if_reg;
  assign AM_BINARY         = am_bin_reg;
  assign AM_TUNED_FREQ     = am_freq_reg;

endmodule // tone_and_am_avoid_regs

`default_nettype wire

// file: rtl/tone_regs_consts.vh
`ifndef TONE_REGS_CONSTS_VH
`define TONE_REGS_CONSTS_VH

// subaddresses of the register bank
`define SUB_BASS_GAIN_INDEX      8'hdb
`define SUB_TREBLE_CORNER_SELECT 8'hdc
`define SUB_TREBLE_GAIN_INDEX    8'hdd
`define SUB_AM_AVOIDANCE_MODE    8'hde

// reset values
`define RST_BASS_GAIN_INDEX      32'h12121212
`define RST_TREBLE_GAIN_INDEX    32'h12121212
`define RST_TREBLE_CORNER_SELECT 32'h00000000
`define RST_AM_AVOIDANCE_MODE    32'h00000000
`define RST_TREBLE_ACTIVE_SET    3'h1

// writable bits; reserved bits store nothing and read zero
`define MASK_TREBLE_CORNER_SELECT 32'h07070707
`define MASK_AM_AVOIDANCE_MODE    32'h011fffff

// gain index mapping
`define GAIN_INDEX_MAX  8'h24
`define GAIN_DB_TOP     6'h12
`define GAIN_DB_BOTTOM  6'h2e
`define GAIN_DB_ZERO    6'h00

// treble set codes
`define TREBLE_CODE_FIRST 3'h1
`define TREBLE_CODE_LAST  3'h5

// am mode field positions
`define AM_METHOD_BIT     24
`define AM_ENABLE_BIT     20
`define AM_SEQ_HI         19
`define AM_SEQ_LO         18
`define AM_IF_BIT         17
`define AM_BINARY_BIT     16
`define AM_BCD_THOUSANDS  12
`define AM_BIN_MSB        10

// serial port byte counting
`define BIT_COUNT_BYTE    4'h8
`define BYTES_PER_WORD_M1 2'h3

`endif

// file: tb/tone_and_am_avoid_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module tone_and_am_avoid_regs_test;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        scl;
  logic        sda_drv;
  logic [3:0]  inline_sel;
  logic        sda_oe;
  logic [31:0] bass_idx;
  logic [31:0] treb_idx;
  logic [23:0] bass_db;
  logic [23:0] treb_db;
  logic [11:0] treb_set;
  wire  [5:0]  am;
  logic [15:0] am_freq;
  logic [31:0] rd;
  int          fails;
  int          cmp_count;
  wire         sda = sda_drv & ~sda_oe;

  tone_and_am_avoid_regs u_tone_and_am_avoid_regs (.CLK(clk), .RSTN(rstn), .CE(ce),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .TONE_INLINE(inline_sel),
    .BASS_GAIN_INDEX(bass_idx), .TREBLE_GAIN_INDEX(treb_idx), .BASS_GAIN_DB(bass_db),
    .TREBLE_GAIN_DB(treb_db), .TREBLE_SET(treb_set), .AM_ENABLE(am[5]),
    .AM_SEQUENCE(am[4:3]), .AM_METHOD(am[2]), .AM_IF_SEL(am[1]), .AM_BINARY(am[0]),
    .AM_TUNED_FREQ(am_freq));

  // 125 MHz
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // six cycles per phase leaves margin over the 4-cycle minimum and sync lag
  task automatic wait_ph;
    repeat (6) @(negedge clk);
  endtask

  task automatic put_bit(input logic b);
    repeat (2) @(negedge clk);
    sda_drv = b;
    wait_ph;
    scl = 1'b1;
    wait_ph;
    scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    repeat (2) @(negedge clk);
    sda_drv = 1'b1;
    wait_ph;
    scl = 1'b1;
    wait_ph;
    b = sda;
    scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    check({31'h0, a}, 32'h0);
  endtask

  task automatic get_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(last);
  endtask

  // also serves as repeated start
  task automatic start;
    wait_ph;
    sda_drv = 1'b1;
    wait_ph;
    scl = 1'b1;
    wait_ph;
    sda_drv = 1'b0;
    wait_ph;
    scl = 1'b0;
  endtask

  task automatic stop;
    wait_ph;
    sda_drv = 1'b0;
    wait_ph;
    scl = 1'b1;
    wait_ph;
    sda_drv = 1'b1;
    wait_ph;
  endtask

  task automatic wr(input logic [7:0] sub, input logic [31:0] d);
    start;
    put_byte(8'h54);
    put_byte(sub);
    for (int i = 3; i >= 0; i--) put_byte(d[8*i+:8]);
    stop;
  endtask

  task automatic rdw(input logic [7:0] sub);
    start;
    put_byte(8'h54);
    put_byte(sub);
    start;
    put_byte(8'h55);
    for (int i = 3; i >= 0; i--) get_byte(i == 0, rd[8*i+:8]);
    stop;
  endtask

  task automatic test_reset;
    check(bass_idx, 32'h12121212);
    check(treb_idx, 32'h12121212);
    check({8'h0, bass_db}, 32'h0);
    check({20'h0, treb_set}, 32'h00000249);
    check({10'h0, am, am_freq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_bass;
    inline_sel = 4'hf;
    wr(8'hdb, 32'h00243012);
    check(bass_idx, 32'h00243012);
    check({8'h0, bass_db}, {8'h0, 6'h12, 6'h2e, 6'h2e, 6'h00});
    rdw(8'hdb);
    check(rd, 32'h00243012);
    inline_sel = 4'h0;
    repeat (2) @(negedge clk);
    check({8'h0, bass_db}, 32'h0);
    $display("test bass done");
  endtask

  task automatic test_treble;
    wr(8'hdc, 32'hfd06f903);
    check({20'h0, treb_set}, {20'h0, 3'h5, 3'h1, 3'h1, 3'h3});
    rdw(8'hdc);
    check(rd, 32'h05060103);
    wr(8'hdc, 32'h00000007);
    check({20'h0, treb_set}, {20'h0, 3'h5, 3'h1, 3'h1, 3'h3});
    inline_sel = 4'hf;
    wr(8'hdd, 32'h11231324);
    check(treb_idx, 32'h11231324);
    check({8'h0, treb_db}, {8'h0, 6'h01, 6'h2f, 6'h3f, 6'h2e});
    $display("test treble done");
  endtask

  task automatic test_am;
    wr(8'hde, 32'hffff1234);
    check({10'h0, am, am_freq}, {10'h0, 6'h3f, 16'h0234});
    rdw(8'hde);
    check(rd, 32'h011f0234);
    wr(8'hde, 32'h00061abc);
    check({10'h0, am, am_freq}, {10'h0, 6'h0a, 16'h1ab0});
    wr(8'hd0, 32'hffffffff);
    rdw(8'hd0);
    check(rd, 32'h0);
    $display("test am done");
  endtask

  // a low enable must freeze the gain outputs even while the inline select drops
  task automatic test_freeze;
    ce = 1'b0;
    inline_sel = 4'h0;
    repeat (3) @(negedge clk);
    check({8'h0, bass_db}, {8'h0, 6'h12, 6'h2e, 6'h2e, 6'h00});
    ce = 1'b1;
    repeat (2) @(negedge clk);
    check({8'h0, bass_db}, 32'h0);
    $display("test freeze done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    scl = 1'b1;
    sda_drv = 1'b1;
    inline_sel = 4'h0;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    test_reset;
    test_bass;
    test_treble;
    test_am;
    test_freeze;
    test_done;
  end
endmodule // tone_and_am_avoid_regs_test
`default_nettype wire

// file: tb/tone_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tone_regs_sva (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire logic        SCL_IN,
  input wire logic        SDA_OUT,
  input wire logic [3:0]  TONE_INLINE,
  input wire logic [31:0] BASS_GAIN_INDEX,
  input wire logic [31:0] TREBLE_GAIN_INDEX,
  input wire logic [23:0] BASS_GAIN_DB,
  input wire logic [23:0] TREBLE_GAIN_DB,
  input wire logic [11:0] TREBLE_SET,
  input wire logic        AM_BINARY,
  input wire logic [15:0] AM_TUNED_FREQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // open-drain: the data line is only ever pulled low
  a_sda_out_low: assert property (SDA_OUT == 1'b0)
    else $error("data output not low");
  a_bass_db_map: assert property (CE && TONE_INLINE[0] && BASS_GAIN_INDEX[7:0] <= 8'h24
    |=> BASS_GAIN_DB[5:0] == 6'h12 - $past(BASS_GAIN_INDEX[5:0]))
    else $error("bass gain mapping wrong");
  a_treble_db_map: assert property (CE && TONE_INLINE[3] && TREBLE_GAIN_INDEX[31:24] <= 8'h24
    |=> TREBLE_GAIN_DB[23:18] == 6'h12 - $past(TREBLE_GAIN_INDEX[29:24]))
    else $error("treble gain mapping wrong");
  a_bypass_zero: assert property (CE && !TONE_INLINE[3] |=> BASS_GAIN_DB[23:18] == 6'h00)
    else $error("bypassed group shows gain");
  a_invalid_sat: assert property (CE && TONE_INLINE[1] && BASS_GAIN_INDEX[15:8] > 8'h24
    |=> BASS_GAIN_DB[11:6] == 6'h2e)
    else $error("invalid index not saturated");
  a_set_legal: assert property (TREBLE_SET[2:0] != 3'h0 && TREBLE_SET[2:0] < 3'h6)
    else $error("treble set out of range");
  a_bin_upper: assert property (AM_BINARY |-> AM_TUNED_FREQ[15:11] == 5'h00)
    else $error("binary frequency upper bits set");
  a_bcd_layout: assert property (!AM_BINARY |-> AM_TUNED_FREQ[15:13] == 3'h0
    && AM_TUNED_FREQ[3:0] == 4'h0) else $error("decimal frequency layout wrong");
  // words commit at a falling serial clock, never mid-high phase
  a_commit_low: assert property ($changed(BASS_GAIN_INDEX) |-> !SCL_IN)
    else $error("index changed while clock high");
endmodule // tone_regs_sva
bind tone_and_am_avoid_regs tone_regs_sva u_tone_regs_sva (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .TONE_INLINE(TONE_INLINE),
  .BASS_GAIN_INDEX(BASS_GAIN_INDEX), .TREBLE_GAIN_INDEX(TREBLE_GAIN_INDEX),
  .BASS_GAIN_DB(BASS_GAIN_DB), .TREBLE_GAIN_DB(TREBLE_GAIN_DB), .TREBLE_SET(TREBLE_SET),
  .AM_BINARY(AM_BINARY), .AM_TUNED_FREQ(AM_TUNED_FREQ));
`default_nettype wire
